//--- include/ftr_pkg.sv
// constants and types for the function terminal router
package ftr_pkg;
  localparam int TERM_N = 10;
  localparam int DIO_W = 8;
  // register byte offsets
  localparam logic [7:0] ADDR_TERM_DIR = 8'h00;
  localparam logic [7:0] ADDR_ROUTE = 8'h04;
  localparam logic [7:0] ADDR_DIO_DIR = 8'h08;
  localparam logic [7:0] ADDR_DIO_OUT = 8'h0C;
  localparam logic [7:0] ADDR_CH_GND = 8'h10;
  localparam logic [7:0] ADDR_CAL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // route register fields
  localparam int RT_B_GATE_ALT = 0;
  localparam int RT_A_SRC_ALT = 1;
  localparam int RT_A_GATE_ALT = 2;
  localparam int RT_START_ALT = 3;
  localparam int RT_FWD_T8 = 4;
  localparam int RT_FWD_T9 = 5;
  localparam int RT_FWD_CA = 6;
  localparam int RT_CA_PIN_OUT = 7;
  localparam int RT_UD_A_EN = 8;
  localparam int RT_UD_B_EN = 9;
  localparam int RT_W = 10;
  // status register fields
  localparam int ST_TERM_LSB = 0;
  localparam int ST_DIO_LSB = 10;
  localparam int ST_CA_PIN = 18;
  localparam int ST_CAL = 19;
  // terminal numbers
  localparam int T_B_GATE = 4;
  localparam int T_UPD_CLK = 5;
  localparam int T_START = 6;
  localparam int T_SMP_CLK = 7;
  localparam int T_A_SRC = 8;
  localparam int T_A_GATE = 9;
  localparam int T_FIRST_OUT = 4;
  // digital port bits steering counter direction
  localparam int DIO_UD_A = 6;
  localparam int DIO_UD_B = 7;
  // reset values
  localparam logic [TERM_N-1:0] RST_TERM_DIR = 10'h000;
  localparam logic [RT_W-1:0] RST_ROUTE = 10'h000;
  localparam logic [DIO_W-1:0] RST_DIO = 8'h00;
  localparam logic RST_CAL = 1'b0;
  typedef enum logic [2:0] {
    SEL_EXT = 3'b001,
    SEL_GND = 3'b010,
    SEL_CAL = 3'b100
  } ftr_insel_t;
endpackage

//--- include/ftr_sync_if.sv
// raw pin levels in, filtered levels out, between router and synchroniser
`timescale 1ns/1ps
interface ftr_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport filt (input raw, output clean);
  modport user (output raw, input clean);
endinterface

//--- design/ftr_sync.sv
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module ftr_sync (
  input wire logic pclk,
  input wire logic presetn,
  ftr_sync_if.filt s
);
  localparam int W = $bits(s.raw);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] clean_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q[i] <= 1'b0;
          s2_q[i] <= 1'b0;
          s3_q[i] <= 1'b0;
          clean_q[i] <= 1'b0;
        end else begin
          s1_q[i] <= s.raw[i];
          s2_q[i] <= s1_q[i];
          s3_q[i] <= s2_q[i];
          // a change counts only once stages two and three agree
          if (s2_q[i] == s3_q[i]) begin
            clean_q[i] <= s3_q[i];
          end
        end
      end
    end
  endgenerate
  assign s.clean = clean_q;
endmodule

//--- design/ftr_router.sv
// function terminal router with apb register file
// Functional notes
// - terminal four input gates counter b
// - terminal four output shows counter b gate
// - counter b pin always shows its output
// - terminal five outputs update clock, falling edge
// - terminal six input starts generation
// - terminal six outputs start trigger, rising edge
// - terminal seven outputs input sample clock
// - terminal eight is counter a source
// - terminal nine is counter a gate
// - terminals eight, nine forward to sync bus
// - counter a pin input forwards to bus
// - counter a pin output shows counter output
// - frequency pin always from frequency generator
// - selectors route external input after reset
// - calibration switches selectors away from external
// - software selects channel ground per channel
// - every channel has own selector and converter
// - port bits individually directed; bits six, seven
`timescale 1ns/1ps
module ftr_router #(
  parameter int NCH = 8
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [ftr_pkg::TERM_N-1:0] function_terminal_in,
  output logic [ftr_pkg::TERM_N-1:0] function_terminal_out,
  output logic [ftr_pkg::TERM_N-1:0] function_terminal_oe,
  input wire logic counter_a_pin_in,
  output logic counter_a_pin_out,
  output logic counter_a_pin_oe,
  output logic counter_b_pin,
  output logic frequency_generator_pin,
  input wire logic [ftr_pkg::DIO_W-1:0] digital_port_in,
  output logic [ftr_pkg::DIO_W-1:0] digital_port_out,
  output logic [ftr_pkg::DIO_W-1:0] digital_port_oe,
  input wire logic counter_a_output,
  input wire logic counter_b_output,
  input wire logic output_update_clock,
  input wire logic generation_start_internal,
  input wire logic input_sample_clock,
  input wire logic frequency_generator,
  input wire logic counter_a_alt_source,
  input wire logic counter_a_alt_gate,
  input wire logic counter_b_alt_gate,
  output logic counter_a_clock_source,
  output logic counter_a_gate,
  output logic counter_b_gate,
  output logic generation_start_trigger,
  output logic counter_a_up,
  output logic counter_b_up,
  output logic [2:0] sync_bus_out,
  output logic [2:0] sync_bus_oe,
  output logic [NCH-1:0][2:0] channel_select,
  output logic [NCH-1:0] convert_strobe
);
  localparam int TN = ftr_pkg::TERM_N;
  localparam int DW = ftr_pkg::DIO_W;
  localparam int SW = TN + DW + 1;
  logic [TN-1:0] dir_q, t_out_q, t_oe_q, t_in;
  logic [ftr_pkg::RT_W-1:0] route_q;
  logic [DW-1:0] dio_dir_q, dio_out_q, dio_in;
  logic [NCH-1:0] ch_gnd_q, conv_q;
  logic [NCH-1:0][2:0] ch_sel_q;
  logic [31:0] prdata_q, rd_data;
  logic [2:0] bus_q, bus_oe_q;
  logic cal_q, pready_q, pslverr_q, ca_out_q, ca_oe_q, cb_pin_q, fg_pin_q;
  logic ca_src_q, ca_gate_q, cb_gate_q, start_q, ud_a_q, ud_b_q, smp_prev_q;
  logic ca_in, rd_err, wr_en, ca_src_d, ca_gate_d, cb_gate_d, start_d;
  ftr_sync_if #(.W(SW)) sif ();
  assign sif.raw = {counter_a_pin_in, digital_port_in, function_terminal_in};
  assign t_in = sif.clean[TN-1:0];
  assign dio_in = sif.clean[TN+DW-1:TN];
  assign ca_in = sif.clean[SW-1];

  ftr_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .s(sif.filt)
  );

  // apb: one wait state, write and read data at the pready edge
  assign wr_en = psel && penable && pready_q && pwrite;

  always_comb begin
    rd_data = 32'h0000_0000;
    rd_err = 1'b0;
    unique case (paddr)
      ftr_pkg::ADDR_TERM_DIR: rd_data[TN-1:0] = dir_q;
      ftr_pkg::ADDR_ROUTE: rd_data[ftr_pkg::RT_W-1:0] = route_q;
      ftr_pkg::ADDR_DIO_DIR: rd_data[DW-1:0] = dio_dir_q;
      ftr_pkg::ADDR_DIO_OUT: rd_data[DW-1:0] = dio_out_q;
      ftr_pkg::ADDR_CH_GND: rd_data[NCH-1:0] = ch_gnd_q;
      ftr_pkg::ADDR_CAL: rd_data[0] = cal_q;
      ftr_pkg::ADDR_STATUS: begin
        rd_data[ftr_pkg::ST_TERM_LSB +: TN] = t_in;
        rd_data[ftr_pkg::ST_DIO_LSB +: DW] = dio_in;
        rd_data[ftr_pkg::ST_CA_PIN] = ca_in;
        rd_data[ftr_pkg::ST_CAL] = cal_q;
      end
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      prdata_q <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= psel && penable && !pready_q;
      if (psel && penable && !pready_q) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_data;
        pslverr_q <= rd_err;
      end else begin
        pslverr_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= ftr_pkg::RST_TERM_DIR;
      route_q <= ftr_pkg::RST_ROUTE;
      dio_dir_q <= ftr_pkg::RST_DIO;
      dio_out_q <= ftr_pkg::RST_DIO;
      ch_gnd_q <= '0;
      cal_q <= ftr_pkg::RST_CAL;
    end else if (wr_en) begin
      unique case (paddr)
        ftr_pkg::ADDR_TERM_DIR: begin
          // terminals below four have no output function
          dir_q <= {pwdata[TN-1:ftr_pkg::T_FIRST_OUT], 4'h0};
        end
        ftr_pkg::ADDR_ROUTE: route_q <= pwdata[ftr_pkg::RT_W-1:0];
        ftr_pkg::ADDR_DIO_DIR: dio_dir_q <= pwdata[DW-1:0];
        ftr_pkg::ADDR_DIO_OUT: dio_out_q <= pwdata[DW-1:0];
        ftr_pkg::ADDR_CH_GND: ch_gnd_q <= pwdata[NCH-1:0];
        ftr_pkg::ADDR_CAL: cal_q <= pwdata[0];
        default: ;
      endcase
    end
  end

  // counter and trigger routing: terminal is default unless alt or driven
  always_comb begin
    cb_gate_d = (route_q[ftr_pkg::RT_B_GATE_ALT] || dir_q[ftr_pkg::T_B_GATE])
      ? counter_b_alt_gate : t_in[ftr_pkg::T_B_GATE];
    start_d = (route_q[ftr_pkg::RT_START_ALT] || dir_q[ftr_pkg::T_START])
      ? generation_start_internal : t_in[ftr_pkg::T_START];
    ca_src_d = (route_q[ftr_pkg::RT_A_SRC_ALT] || dir_q[ftr_pkg::T_A_SRC])
      ? counter_a_alt_source : t_in[ftr_pkg::T_A_SRC];
    ca_gate_d = (route_q[ftr_pkg::RT_A_GATE_ALT] || dir_q[ftr_pkg::T_A_GATE])
      ? counter_a_alt_gate : t_in[ftr_pkg::T_A_GATE];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_gate_q <= 1'b0;
      start_q <= 1'b0;
      ca_src_q <= 1'b0;
      ca_gate_q <= 1'b0;
    end else begin
      cb_gate_q <= cb_gate_d;
      start_q <= start_d;
      ca_src_q <= ca_src_d;
      ca_gate_q <= ca_gate_d;
    end
  end

  // terminal drivers; enables follow direction bits only
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t_out_q <= '0;
      t_oe_q <= '0;
    end else begin
      t_oe_q <= dir_q;
      t_out_q <= '0;
      t_out_q[ftr_pkg::T_B_GATE] <= cb_gate_d;
      t_out_q[ftr_pkg::T_UPD_CLK] <= output_update_clock;
      t_out_q[ftr_pkg::T_START] <= start_d;
      t_out_q[ftr_pkg::T_SMP_CLK] <= input_sample_clock;
      t_out_q[ftr_pkg::T_A_SRC] <= ca_src_d;
      t_out_q[ftr_pkg::T_A_GATE] <= ca_gate_d;
    end
  end

  // dedicated counter and frequency pins, sync bus forwarding
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cb_pin_q <= 1'b0;
      fg_pin_q <= 1'b0;
      ca_out_q <= 1'b0;
      ca_oe_q <= 1'b0;
      bus_q <= 3'h0;
      bus_oe_q <= 3'h0;
    end else begin
      cb_pin_q <= counter_b_output;
      fg_pin_q <= frequency_generator;
      ca_out_q <= counter_a_output;
      ca_oe_q <= route_q[ftr_pkg::RT_CA_PIN_OUT];
      bus_q <= {ca_in, t_in[ftr_pkg::T_A_GATE], t_in[ftr_pkg::T_A_SRC]};
      bus_oe_q <= {route_q[ftr_pkg::RT_FWD_CA] && !route_q[ftr_pkg::RT_CA_PIN_OUT],
                   route_q[ftr_pkg::RT_FWD_T9] && !dir_q[ftr_pkg::T_A_GATE],
                   route_q[ftr_pkg::RT_FWD_T8] && !dir_q[ftr_pkg::T_A_SRC]};
    end
  end

  // counter direction from digital port bits six and seven, default up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ud_a_q <= 1'b1;
      ud_b_q <= 1'b1;
    end else begin
      ud_a_q <= !route_q[ftr_pkg::RT_UD_A_EN] || (dio_dir_q[ftr_pkg::DIO_UD_A]
        ? dio_out_q[ftr_pkg::DIO_UD_A] : dio_in[ftr_pkg::DIO_UD_A]);
      ud_b_q <= !route_q[ftr_pkg::RT_UD_B_EN] || (dio_dir_q[ftr_pkg::DIO_UD_B]
        ? dio_out_q[ftr_pkg::DIO_UD_B] : dio_in[ftr_pkg::DIO_UD_B]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      smp_prev_q <= 1'b0;
    end else begin
      smp_prev_q <= input_sample_clock;
    end
  end

  // per-channel selector and simultaneous convert strobe
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          ch_sel_q[c] <= ftr_pkg::SEL_EXT;
          conv_q[c] <= 1'b0;
        end else begin
          if (cal_q) begin
            ch_sel_q[c] <= ftr_pkg::SEL_CAL;
          end else if (ch_gnd_q[c]) begin
            ch_sel_q[c] <= ftr_pkg::SEL_GND;
          end else begin
            ch_sel_q[c] <= ftr_pkg::SEL_EXT;
          end
          conv_q[c] <= input_sample_clock && !smp_prev_q;
        end
      end
    end
  endgenerate

  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign function_terminal_out = t_out_q;
  assign function_terminal_oe = t_oe_q;
  assign counter_a_pin_out = ca_out_q;
  assign counter_a_pin_oe = ca_oe_q;
  assign counter_b_pin = cb_pin_q;
  assign frequency_generator_pin = fg_pin_q;
  assign digital_port_out = dio_out_q;
  assign digital_port_oe = dio_dir_q;
  assign counter_a_clock_source = ca_src_q;
  assign counter_a_gate = ca_gate_q;
  assign counter_b_gate = cb_gate_q;
  assign generation_start_trigger = start_q;
  assign counter_a_up = ud_a_q;
  assign counter_b_up = ud_b_q;
  assign sync_bus_out = bus_q;
  assign sync_bus_oe = bus_oe_q;
  assign channel_select = ch_sel_q;
  assign convert_strobe = conv_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_b_gate_in;
    !dir_q[4] && !route_q[0] |=> counter_b_gate == $past(t_in[4]);
  endproperty
  a_b_gate_in: assert property (p_b_gate_in) else $error("gate b not from terminal");
  property p_b_gate_out;
    dir_q[4] |=> function_terminal_oe[4] && function_terminal_out[4] == counter_b_gate;
  endproperty
  a_b_gate_out: assert property (p_b_gate_out) else $error("terminal four gate mismatch");
  property p_b_pin;
    ##1 counter_b_pin == $past(counter_b_output);
  endproperty
  a_b_pin: assert property (p_b_pin) else $error("counter b pin mismatch");
  property p_upd_clk;
    dir_q[5] && $fell(output_update_clock) |=> $fell(function_terminal_out[5]);
  endproperty
  a_upd_clk: assert property (p_upd_clk) else $error("update clock edge lost");
  property p_start;
    dir_q[6] |=> function_terminal_out[6] == generation_start_trigger;
  endproperty
  a_start: assert property (p_start) else $error("start trigger pin mismatch");
  property p_a_src;
    dir_q[8] |=> function_terminal_out[8] == counter_a_clock_source;
  endproperty
  a_a_src: assert property (p_a_src) else $error("source pin mismatch");
  property p_fwd;
    route_q[4] && !dir_q[8] |=> sync_bus_oe[0] && sync_bus_out[0] == $past(t_in[8]);
  endproperty
  a_fwd: assert property (p_fwd) else $error("terminal eight not forwarded");
  property p_freq;
    ##1 frequency_generator_pin == $past(frequency_generator);
  endproperty
  a_freq: assert property (p_freq) else $error("frequency pin mismatch");
  sequence s_gnd_write;
    wr_en && paddr == ftr_pkg::ADDR_CH_GND && pwdata[0] && !cal_q;
  endsequence
  sequence s_gnd_seen;
    ##1 channel_select[0] == ftr_pkg::SEL_GND;
  endsequence
  property p_gnd;
    s_gnd_write ##1 !cal_q |-> s_gnd_seen;
  endproperty
  a_gnd: assert property (p_gnd) else $error("ground select not applied");
  property p_cal;
    cal_q |=> channel_select[NCH-1] == ftr_pkg::SEL_CAL;
  endproperty
  a_cal: assert property (p_cal) else $error("calibration select missing");
  property p_conv;
    $rose(input_sample_clock) |=> convert_strobe == {NCH{1'b1}} ##1 convert_strobe == '0;
  endproperty
  a_conv: assert property (p_conv) else $error("convert strobes not simultaneous");
  property p_off;
    !dir_q[7] |=> !function_terminal_oe[7];
  endproperty
  a_off: assert property (p_off) else $error("undirected terminal driven");
endmodule

//--- verif/ftr_ext_model.sv
// connector-side circuitry that drives the terminals and pins when the router does not
`timescale 1ns/1ps
module ftr_ext_model (
  input wire logic [ftr_pkg::TERM_N-1:0] term_drive,
  input wire logic [ftr_pkg::TERM_N-1:0] term_out,
  input wire logic [ftr_pkg::TERM_N-1:0] term_oe,
  output logic [ftr_pkg::TERM_N-1:0] term_level,
  input wire logic ca_drive,
  input wire logic ca_out,
  input wire logic ca_oe,
  output logic ca_level,
  input wire logic [ftr_pkg::DIO_W-1:0] dio_drive,
  input wire logic [ftr_pkg::DIO_W-1:0] dio_out,
  input wire logic [ftr_pkg::DIO_W-1:0] dio_oe,
  output logic [ftr_pkg::DIO_W-1:0] dio_level
);
  // outside source yields wherever the router drives
  always_comb begin
    for (int i = 0; i < ftr_pkg::TERM_N; i++) begin
      term_level[i] = term_oe[i] ? term_out[i] : term_drive[i];
    end
    for (int i = 0; i < ftr_pkg::DIO_W; i++) begin
      dio_level[i] = dio_oe[i] ? dio_out[i] : dio_drive[i];
    end
    ca_level = ca_oe ? ca_out : ca_drive;
  end
endmodule

//--- verif/function_terminal_router_tb_top.sv
// self-checking bench for the function terminal router
`timescale 1ns/1ps
module function_terminal_router_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [9:0] t_in, t_out, t_oe, t_ext;
  logic ca_in, ca_out, ca_oe, ca_ext, cb_pin, fq_pin, err;
  logic [7:0] d_in, d_out, d_oe, d_ext;
  logic [8:0] intl;
  logic ca_src, ca_gate, cb_gate, gst, ca_up, cb_up;
  logic [2:0] sb_out, sb_oe;
  logic [7:0][2:0] ch_sel;
  logic [7:0] cnv;
  logic [31:0] seed, r;
  int miscompares, n_checks, nfull, npart;
  int shadow[7];
  ftr_router #(.NCH(8)) ftr_router_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .function_terminal_in(t_in),
    .function_terminal_out(t_out), .function_terminal_oe(t_oe), .counter_a_pin_in(ca_in),
    .counter_a_pin_out(ca_out), .counter_a_pin_oe(ca_oe), .counter_b_pin(cb_pin),
    .frequency_generator_pin(fq_pin), .digital_port_in(d_in), .digital_port_out(d_out),
    .digital_port_oe(d_oe), .counter_a_output(intl[0]), .counter_b_output(intl[1]),
    .output_update_clock(intl[2]), .generation_start_internal(intl[3]),
    .input_sample_clock(intl[4]), .frequency_generator(intl[5]),
    .counter_a_alt_source(intl[6]), .counter_a_alt_gate(intl[7]),
    .counter_b_alt_gate(intl[8]), .counter_a_clock_source(ca_src),
    .counter_a_gate(ca_gate), .counter_b_gate(cb_gate), .generation_start_trigger(gst),
    .counter_a_up(ca_up), .counter_b_up(cb_up), .sync_bus_out(sb_out), .sync_bus_oe(sb_oe),
    .channel_select(ch_sel), .convert_strobe(cnv));
  ftr_ext_model ftr_ext_model_inst (.term_drive(t_ext), .term_out(t_out), .term_oe(t_oe),
    .term_level(t_in), .ca_drive(ca_ext), .ca_out(ca_out), .ca_oe(ca_oe), .ca_level(ca_in),
    .dio_drive(d_ext), .dio_out(d_out), .dio_oe(d_oe), .dio_level(d_in));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for pready high at a rising edge; data taken at that edge
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (wr && a < 8'h18) begin
      shadow[a >> 2] = wd;
    end
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask
  initial begin
    #(50 * 20000);
    miscompares++;
    wrap_up();
  end
  initial begin
    seed = 32'h98FB;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    t_ext = 10'h000;
    ca_ext = 1'b0;
    d_ext = 8'h00;
    intl = 9'h000;
    miscompares = 0;
    n_checks = 0;
    presetn = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk("term_oe", t_oe, 0);
    chk("up_a_b", {ca_up, cb_up}, 2'b11);
    for (int i = 0; i < 8; i++) chk("ch_sel", ch_sel[i], ftr_pkg::SEL_EXT);
    // terminals as inputs, or the alternate internal sources, feed the counters and start trigger
    for (int n = 0; n < 4; n++) begin
      @(posedge pclk);
      r = xs();
      t_ext <= r[9:0];
      intl <= r[24:16];
      apb(1'b1, ftr_pkg::ADDR_ROUTE, (n % 2) ? 32'h0000000F : 32'h0);
      settle(8);
      chk("cb_gate", cb_gate, (n % 2) ? r[24] : r[4]);
      chk("gen_start", gst, (n % 2) ? r[19] : r[6]);
      chk("ca_src", ca_src, (n % 2) ? r[22] : r[8]);
      chk("ca_gate", ca_gate, (n % 2) ? r[23] : r[9]);
    end
    apb(1'b1, ftr_pkg::ADDR_TERM_DIR, 32'h3FF);
    apb(1'b1, ftr_pkg::ADDR_ROUTE, 32'h080);
    apb(1'b0, ftr_pkg::ADDR_TERM_DIR, 0);
    chk("term_dir_rd", rd, shadow[0] & 32'h3F0);
    apb(1'b0, ftr_pkg::ADDR_ROUTE, 0);
    chk("route_rd", rd, shadow[1] & 32'h3FF);
    settle(1);
    chk("term_oe", t_oe, 10'h3F0);
    chk("ca_oe", ca_oe, 1'b1);
    // terminals as outputs follow internal signals one cycle later
    for (int n = 0; n < 40; n++) begin
      @(posedge pclk);
      r = xs();
      intl <= r[8:0];
      t_ext <= r[18:9];
      settle(1);
      chk("cb_pin", cb_pin, r[1]);
      chk("fq_pin", fq_pin, r[5]);
      chk("ca_pin_out", ca_out, r[0]);
      chk("t4", t_out[4], r[8]);
      chk("cb_gate_out", cb_gate, r[8]);
      chk("t5", t_out[5], r[2]);
      chk("t6", t_out[6], r[3]);
      chk("t7", t_out[7], r[4]);
      chk("t8", t_out[8], r[6]);
      chk("t9", t_out[9], r[7]);
    end
    // one simultaneous strobe per rising sample clock
    nfull = 0;
    npart = 0;
    @(posedge pclk);
    intl <= 9'h000;
    settle(3);
    @(posedge pclk);
    intl <= 9'h010;
    repeat (8) begin
      @(negedge pclk);
      if (cnv === 8'hFF) nfull++;
      else if (cnv !== 8'h00) npart++;
    end
    chk("strobe_full", nfull, 1);
    chk("strobe_part", npart, 0);
    // forwarding to the sync bus
    apb(1'b1, ftr_pkg::ADDR_TERM_DIR, 0);
    apb(1'b1, ftr_pkg::ADDR_ROUTE, 32'h070);
    for (int n = 0; n < 3; n++) begin
      @(posedge pclk);
      r = xs();
      t_ext <= r[9:0];
      ca_ext <= r[10];
      settle(8);
      chk("sb_oe", sb_oe, 3'b111);
      chk("sb_out", sb_out, {r[10], r[9], r[8]});
      apb(1'b0, ftr_pkg::ADDR_STATUS, 0);
      chk("status_rd", rd, {r[10], 8'h00, r[9:0]});
    end
    apb(1'b1, ftr_pkg::ADDR_TERM_DIR, 32'h100);
    settle(8);
    chk("sb_oe_t8out", sb_oe, 3'b110);
    // selectors: ground, calibration, back to external
    for (int p = 0; p < 3; p++) begin
      r = xs();
      r[0] = 1'b1;
      apb(1'b1, ftr_pkg::ADDR_CH_GND, (p == 2) ? 0 : r[7:0]);
      apb(1'b1, ftr_pkg::ADDR_CAL, (p == 1) ? 1 : 0);
      settle(2);
      for (int i = 0; i < 8; i++) begin
        if (p == 1) chk("ch_sel_cal", ch_sel[i], ftr_pkg::SEL_CAL);
        else if (p == 0 && r[i]) chk("ch_sel_gnd", ch_sel[i], ftr_pkg::SEL_GND);
        else chk("ch_sel_ext", ch_sel[i], ftr_pkg::SEL_EXT);
      end
    end
    // digital port direction and counter direction control
    apb(1'b1, ftr_pkg::ADDR_ROUTE, 32'h300);
    for (int n = 0; n < 3; n++) begin
      @(posedge pclk);
      r = xs();
      d_ext <= r[15:8];
      apb(1'b1, ftr_pkg::ADDR_DIO_DIR, {r[7], 1'b1, r[5:0]} & 8'h7F);
      apb(1'b1, ftr_pkg::ADDR_DIO_OUT, r[23:16]);
      settle(8);
      chk("dio_oe", d_oe, shadow[2][7:0]);
      chk("dio_out", d_out, r[23:16]);
      chk("ca_up", ca_up, r[22]);
      chk("cb_up", cb_up, r[15]);
    end
    // mid-run reset with ground selected: selectors return to external
    apb(1'b1, ftr_pkg::ADDR_CH_GND, 32'h000000FF);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    settle(1);
    for (int i = 0; i < 8; i++) chk("ch_sel_rst", ch_sel[i], ftr_pkg::SEL_EXT);
    chk("term_oe_rst", t_oe, 0);
    apb(1'b1, 8'h1C, 32'hFFFFFFFF);
    chk("unmapped_wr_err", err, 1'b1);
    apb(1'b0, 8'h1C, 0);
    chk("unmapped_rd_err", err, 1'b1);
    chk("unmapped_rd", rd, 0);
    wrap_up();
  end
endmodule
